// [common/gsl_defs.svh]
// Constants of the gray-shade column loader
`ifndef GSL_DEFS_SVH
`define GSL_DEFS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define GSL_COLUMNS       32
`define GSL_CODE_W        7

// ----------------------------------------------------------------
// Pin sampling vector, bit positions
// ----------------------------------------------------------------
`define GSL_PIN_W         13
`define GSL_PIN_SC        0
`define GSL_PIN_LC        1
`define GSL_PIN_CC        2
`define GSL_PIN_DIR       3
`define GSL_PIN_TA        4
`define GSL_PIN_TB        5
`define GSL_PIN_BUS_LO    6
`define GSL_PIN_BUS_HI    12

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define GSL_CNT_MAX       7'h7f
`define GSL_EXIT_EDGES    2'h2
`define GSL_CODE_RST      7'h00

`endif

// [common/gsl_pkg.sv]
// Types of the gray-shade column loader
package gsl_pkg;

    // Loading sequencer states, one-hot
    typedef enum logic [2:0] {
        GSL_IDLE = 3'b001,
        GSL_LOAD = 3'b010,
        GSL_PASS = 3'b100
    } gsl_load_state_type;

endpackage : gsl_pkg

// [core/gsl_loader.sv]
// Gray-shade column loader: token loading and level conversion logic
//
// Functional notes
// - Loading of shade codes into the latch sets starts only while the entry token is present.
// - Direction high: token enters port A, columns fill 1 up to 32.
// - First shift-clock rise with token loads first set, once per arrival.
// - Each later shift-clock edge, either polarity, loads the next set.
// - After the last column of the fill loads (32, or 1 going down), token is driven out on the exit port.
// - Direction low: enter port B, exit port A, fill 32 down to 1.
// - Transfer rise clears outputs and copies input latches to comparators.
// - Transfer fall starts the conversion phase.
// - Level count clock steps the 7-bit counter from 0 to 127.
// - During conversion each stored code is compared with the counter.
`timescale 1ns/1ps
`include "gsl_defs.svh"

module gsl_loader
    import gsl_pkg::*;
#(
    parameter int N_COLS = `GSL_COLUMNS,
    parameter int CODE_W = `GSL_CODE_W
)
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Controller pins
    input  wire logic                  column_shift_clock,
    input  wire logic                  transfer_strobe,
    input  wire logic                  level_count_clock,
    input  wire logic                  shift_dir,
    input  wire logic [CODE_W-1:0]     shade_code_bus,
    // Token pins, two-way
    input  wire logic                  token_port_a_in,
    output logic                       token_port_a_out,
    output logic                       token_port_a_oe,
    input  wire logic                  token_port_b_in,
    output logic                       token_port_b_out,
    output logic                       token_port_b_oe,
    // Column drive state
    output logic [N_COLS-1:0]          column_output,
    output logic [N_COLS-1:0]          channel_done,
    output logic [CODE_W-1:0]          level_count,
    output logic                       converting
);

    localparam int IDX_W = $clog2(N_COLS);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_COLS - 1);

    // ----------------------------------------------------------------
    // Pin synchroniser and edge finder
    // ----------------------------------------------------------------
    logic [`GSL_PIN_W-1:0] pin_raw;
    logic [`GSL_PIN_W-1:0] sync1_r;
    logic [`GSL_PIN_W-1:0] sync2_r;
    logic [`GSL_PIN_W-1:0] prev_r;

    assign pin_raw = {shade_code_bus, token_port_b_in, token_port_a_in,
                      shift_dir, level_count_clock, transfer_strobe,
                      column_shift_clock};

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    logic              sc_edge;
    logic              sc_rise;
    logic              lc_rise;
    logic              lc_fall;
    logic              cc_rise;
    logic              dir_s;
    logic              tok_in;
    logic [CODE_W-1:0] bus_s;

    assign sc_edge = sync2_r[`GSL_PIN_SC] ^ prev_r[`GSL_PIN_SC];
    assign sc_rise = sync2_r[`GSL_PIN_SC] & ~prev_r[`GSL_PIN_SC];
    assign lc_rise = sync2_r[`GSL_PIN_LC] & ~prev_r[`GSL_PIN_LC];
    assign lc_fall = ~sync2_r[`GSL_PIN_LC] & prev_r[`GSL_PIN_LC];
    assign cc_rise = sync2_r[`GSL_PIN_CC] & ~prev_r[`GSL_PIN_CC];
    assign dir_s   = sync2_r[`GSL_PIN_DIR];
    assign bus_s   = sync2_r[`GSL_PIN_BUS_HI:`GSL_PIN_BUS_LO];
    // Entry port follows direction
    assign tok_in  = dir_s ? sync2_r[`GSL_PIN_TA]
                           : sync2_r[`GSL_PIN_TB];

    // ----------------------------------------------------------------
    // Token sequencer
    // ----------------------------------------------------------------
    gsl_load_state_type st_r, st_nxt;
    logic [IDX_W-1:0]   lcnt_r, lcnt_nxt;
    logic [1:0]         ecnt_r, ecnt_nxt;
    logic               dir_r, dir_nxt;
    logic               consumed_r, consumed_nxt;
    logic               exit_a_r, exit_a_nxt;
    logic               exit_b_r, exit_b_nxt;
    logic               wr_en;
    logic [IDX_W-1:0]   wr_idx;

    always_comb
    begin
        st_nxt       = st_r;
        lcnt_nxt     = lcnt_r;
        ecnt_nxt     = ecnt_r;
        dir_nxt      = dir_r;
        consumed_nxt = consumed_r;
        exit_a_nxt   = exit_a_r;
        exit_b_nxt   = exit_b_r;
        wr_en        = 1'b0;
        wr_idx       = '0;
        // Arrival is re-armed once the entry token drops
        if (!tok_in)
            consumed_nxt = 1'b0;
        unique case (st_r)
            GSL_IDLE:
            begin
                if (tok_in && !consumed_r && sc_rise)
                begin
                    wr_en        = 1'b1;
                    wr_idx       = dir_s ? '0 : LAST_IDX;
                    dir_nxt      = dir_s;
                    lcnt_nxt     = IDX_W'(1);
                    consumed_nxt = 1'b1;
                    st_nxt       = GSL_LOAD;
                end
            end
            GSL_LOAD:
            begin
                if (sc_edge)
                begin
                    wr_en    = 1'b1;
                    wr_idx   = dir_r ? lcnt_r : LAST_IDX - lcnt_r;
                    lcnt_nxt = lcnt_r + IDX_W'(1);
                    if (lcnt_r == LAST_IDX)
                    begin
                        st_nxt     = GSL_PASS;
                        ecnt_nxt   = '0;
                        exit_a_nxt = ~dir_r;
                        exit_b_nxt = dir_r;
                    end
                end
            end
            GSL_PASS:
            begin
                // Exit token stands over the next chip's first rise
                if (sc_edge)
                begin
                    ecnt_nxt = ecnt_r + 2'h1;
                    if (ecnt_r + 2'h1 == `GSL_EXIT_EDGES)
                    begin
                        st_nxt     = GSL_IDLE;
                        exit_a_nxt = 1'b0;
                        exit_b_nxt = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r       <= GSL_IDLE;
            lcnt_r     <= '0;
            ecnt_r     <= '0;
            dir_r      <= 1'b1;
            consumed_r <= 1'b0;
            exit_a_r   <= 1'b0;
            exit_b_r   <= 1'b0;
        end
        else
        begin
            st_r       <= st_nxt;
            lcnt_r     <= lcnt_nxt;
            ecnt_r     <= ecnt_nxt;
            dir_r      <= dir_nxt;
            consumed_r <= consumed_nxt;
            exit_a_r   <= exit_a_nxt;
            exit_b_r   <= exit_b_nxt;
        end
    end

    assign token_port_a_out = exit_a_r;
    assign token_port_b_out = exit_b_r;
    assign token_port_a_oe  = ~dir_s;
    assign token_port_b_oe  = dir_s;

    // ----------------------------------------------------------------
    // Input latches, comparator latches and conversion
    // ----------------------------------------------------------------
    logic [N_COLS-1:0][CODE_W-1:0] lat_r, lat_nxt;
    logic [N_COLS-1:0][CODE_W-1:0] cmp_r, cmp_nxt;
    logic [N_COLS-1:0]             done_r, done_nxt;
    logic [N_COLS-1:0]             follow_r, follow_nxt;
    logic [CODE_W-1:0]             cnt_r, cnt_nxt;
    logic                          conv_r, conv_nxt;

    always_comb
    begin
        lat_nxt = lat_r;
        if (wr_en)
            lat_nxt[wr_idx] = bus_s;
    end

    always_comb
    begin
        cmp_nxt  = cmp_r;
        done_nxt = done_r;
        cnt_nxt  = cnt_r;
        conv_nxt = conv_r;
        if (lc_rise)
        begin
            cmp_nxt  = lat_r;
            done_nxt = '0;
            conv_nxt = 1'b0;
            cnt_nxt  = '0;
        end
        else
        begin
            if (lc_fall)
            begin
                conv_nxt = 1'b1;
                cnt_nxt  = '0;
            end
            else if (conv_r && cc_rise && cnt_r != `GSL_CNT_MAX)
                cnt_nxt = cnt_r + CODE_W'(1);
            // Reached channels latch and hold
            for (int i = 0; i < N_COLS; i++)
                if (conv_r && cnt_r == cmp_r[i])
                    done_nxt[i] = 1'b1;
        end
        follow_nxt = conv_nxt ? ~done_nxt : '0;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lat_r    <= {N_COLS{`GSL_CODE_RST}};
            cmp_r    <= {N_COLS{`GSL_CODE_RST}};
            done_r   <= '0;
            follow_r <= '0;
            cnt_r    <= '0;
            conv_r   <= 1'b0;
        end
        else
        begin
            lat_r    <= lat_nxt;
            cmp_r    <= cmp_nxt;
            done_r   <= done_nxt;
            follow_r <= follow_nxt;
            cnt_r    <= cnt_nxt;
            conv_r   <= conv_nxt;
        end
    end

    assign column_output = follow_r;
    assign channel_done  = done_r;
    assign level_count   = cnt_r;
    assign converting    = conv_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    property p_write_needs_token;
        wr_en && st_r == GSL_IDLE |-> tok_in && sc_rise;
    endproperty
    a_write_needs_token: assert property (p_write_needs_token)
        else $error("latch write without entry token");

    property p_first_index;
        wr_en && st_r == GSL_IDLE |=>
            lat_r[dir_r ? 0 : N_COLS-1] == $past(bus_s) && st_r == GSL_LOAD;
    endproperty
    a_first_index: assert property (p_first_index)
        else $error("first code not in end column");

    property p_once_per_arrival;
        st_r == GSL_IDLE && consumed_r && tok_in |-> !wr_en;
    endproperty
    a_once_per_arrival: assert property (p_once_per_arrival)
        else $error("second load on same token arrival");

    property p_each_edge_loads;
        st_r == GSL_LOAD && sc_edge |->
            wr_en ##1 (lcnt_r == $past(lcnt_r) + IDX_W'(1)
                       || st_r == GSL_PASS);
    endproperty
    a_each_edge_loads: assert property (p_each_edge_loads)
        else $error("shift edge did not advance token");

    property p_exit_token;
        st_r == GSL_LOAD && sc_edge && lcnt_r == LAST_IDX |=>
            (dir_r ? token_port_b_out : token_port_a_out)
            [*2];
    endproperty
    a_exit_token: assert property (p_exit_token)
        else $error("exit token not driven after last column");

    property p_descending;
        st_r == GSL_LOAD && wr_en && !dir_r |->
            wr_idx == LAST_IDX - lcnt_r && !exit_b_r;
    endproperty
    a_descending: assert property (p_descending)
        else $error("descending fill index wrong");

    property p_transfer_copy;
        lc_rise |=> cmp_r == $past(lat_r) && column_output == '0
                    && !converting;
    endproperty
    a_transfer_copy: assert property (p_transfer_copy)
        else $error("transfer did not copy and clear");

    property p_conv_start;
        lc_fall |=> converting && level_count == '0;
    endproperty
    a_conv_start: assert property (p_conv_start)
        else $error("conversion not started on transfer fall");

    property p_count_step;
        conv_r && !lc_rise && !lc_fall && cc_rise
            && cnt_r != `GSL_CNT_MAX |=> cnt_r == $past(cnt_r) + CODE_W'(1);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step");

    property p_count_saturate;
        conv_r && cnt_r == `GSL_CNT_MAX && !lc_rise |=> cnt_r == `GSL_CNT_MAX;
    endproperty
    a_count_saturate: assert property (p_count_saturate)
        else $error("counter passed top code");

    property p_compare;
        conv_r && !lc_rise && cnt_r == cmp_r[0] |=>
            channel_done[0] && !column_output[0];
    endproperty
    a_compare: assert property (p_compare)
        else $error("channel not flagged on code match");

    property p_hold;
        done_r[0] && !lc_rise |=> done_r[0] [*1] ##0 !column_output[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("flagged channel resumed following");

    c_fill_up: cover property (st_r == GSL_LOAD && dir_r
                               ##1 st_r == GSL_PASS);
    c_fill_down: cover property (st_r == GSL_LOAD && !dir_r
                                 ##1 st_r == GSL_PASS);
    c_count_top: cover property (conv_r && cnt_r == `GSL_CNT_MAX);
    c_transfer: cover property (lc_rise ##[1:50] lc_fall);

endmodule : gsl_loader

// [dv/gsl_ctl_model.sv]
// Display controller model driving the loader pins
`timescale 1ns/1ps
`include "gsl_defs.svh"

module gsl_ctl_model
    import gsl_pkg::*;
(
    // Clock
    input  wire logic               mclk,
    // Pins towards the loader
    output logic                    shift_clk,
    output logic                    xfer,
    output logic                    cnt_clk,
    output logic                    dir,
    output logic [`GSL_CODE_W-1:0]  code,
    output logic                    tok_a,
    output logic                    tok_b
);
    initial
    begin
        shift_clk = 1'b0;
        xfer = 1'b0;
        cnt_clk = 1'b0;
        dir = 1'b1;
        code = 7'h00;
        tok_a = 1'b0;
        tok_b = 1'b0;
    end

    // ----
    // Pin sequences
    // ----
    task automatic set_pins(input logic d, input logic a, input logic b);
        @(posedge mclk);
        dir <= d;
        tok_a <= a;
        tok_b <= b;
        repeat (4) @(posedge mclk);
    endtask : set_pins

    // Fresh code, then one shift edge; code held 3 cycles past it
    task automatic shift_edge(input logic [`GSL_CODE_W-1:0] v);
        @(posedge mclk);
        code <= v;
        @(posedge mclk);
        shift_clk <= ~shift_clk;
        repeat (2) @(posedge mclk);
    endtask : shift_edge

    // Called only once every column is loaded
    task automatic strobe(input logic level);
        @(posedge mclk);
        shift_clk <= 1'b0;
        cnt_clk <= 1'b0;
        xfer <= level;
        repeat (4) @(posedge mclk);
    endtask : strobe

    task automatic count_pulse;
        @(posedge mclk);
        cnt_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        cnt_clk <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : count_pulse
endmodule : gsl_ctl_model

// [dv/gsl_loader_tb.sv]
// Self-checking bench of the gray-shade column loader
`timescale 1ns/1ps
`include "gsl_defs.svh"

module gsl_loader_tb
    import gsl_pkg::*;
;
    logic        mclk;
    logic        resetn;
    logic        shift_clk;
    logic        xfer;
    logic        cnt_clk;
    logic        dir;
    logic [6:0]  code;
    logic        tok_a;
    logic        tok_b;
    logic        a_in;
    logic        a_out;
    logic        a_oe;
    logic        b_in;
    logic        b_out;
    logic        b_oe;
    logic [31:0] col_out;
    logic [31:0] done;
    logic [6:0]  count;
    logic        conv;
    logic [6:0]  seq [32];
    logic [6:0]  col [32];
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_cyc = 0;

    // Token pins: the enabled party drives the wire
    assign a_in = a_oe ? a_out : tok_a;
    assign b_in = b_oe ? b_out : tok_b;

    gsl_loader u_dut (
        .mclk(mclk), .resetn(resetn),
        .column_shift_clock(shift_clk), .transfer_strobe(xfer),
        .level_count_clock(cnt_clk), .shift_dir(dir),
        .shade_code_bus(code),
        .token_port_a_in(a_in), .token_port_a_out(a_out),
        .token_port_a_oe(a_oe), .token_port_b_in(b_in),
        .token_port_b_out(b_out), .token_port_b_oe(b_oe),
        .column_output(col_out), .channel_done(done),
        .level_count(count), .converting(conv)
    );

    gsl_ctl_model u_ctl (
        .mclk(mclk), .shift_clk(shift_clk), .xfer(xfer),
        .cnt_clk(cnt_clk), .dir(dir), .code(code),
        .tok_a(tok_a), .tok_b(tok_b)
    );

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ----
    // Checking and closing
    // ----
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    always @(posedge mclk)
    begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 10000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] exp_done(input int n);
        logic [31:0] m;
        m = 32'h0;
        for (int k = 0; k < 32; k++)
            m[k] = (int'(col[k]) <= n);
        return m;
    endfunction : exp_done

    // Loads 32 codes, then 4 spare edges that must load nothing
    task automatic load32(input logic d, input logic hold);
        logic x;
        u_ctl.set_pins(d, 1'b0, 1'b0);
        u_ctl.set_pins(d, d, !d);
        check("exit_oe", 32'(d ? b_oe : a_oe), 32'h1);
        for (int e = 0; e < 36; e++)
        begin
            u_ctl.shift_edge(e < 32 ? seq[e] : 7'h55);
            if (e == 0 && !hold)
                u_ctl.set_pins(d, 1'b0, 1'b0);
            // Look once the edge has reached the exit pin
            if (e >= 30)
                @(posedge mclk);
            @(negedge mclk);
            x = d ? b_out : a_out;
            if (e >= 30)
                check("exit_tok", 32'(x), 32'(e == 31 || e == 32));
        end
        u_ctl.set_pins(d, 1'b0, 1'b0);
    endtask : load32

    task automatic convert(input int n);
        u_ctl.strobe(1'b1);
        @(negedge mclk);
        check("out_clear", col_out, 32'h0);
        check("done_clear", done, 32'h0);
        check("conv_off", 32'(conv), 32'h0);
        u_ctl.strobe(1'b0);
        for (int i = 0; i <= n; i++)
        begin
            if (i > 0)
                u_ctl.count_pulse();
            @(posedge mclk);
            @(negedge mclk);
            check("conv_on", 32'(conv), 32'h1);
            check("count", 32'(count), 32'(i > 127 ? 127 : i));
            check("done", done, exp_done(i));
            check("follow", col_out, ~exp_done(i));
        end
    endtask : convert

    // ----
    // Scenarios
    // ----
    task automatic test_reset;
        @(negedge mclk);
        check("rst_out", col_out | done, 32'h0);
        check("rst_cnt", 32'({count, conv, b_oe}), 32'h0);
        @(posedge mclk);
    endtask : test_reset

    // Ascending fill, entry token held high past the load
    task automatic test_up;
        for (int k = 0; k < 32; k++)
        begin
            seq[k] = (k == 31) ? 7'h7f : 7'(k * 4);
            col[k] = seq[k];
        end
        u_ctl.shift_edge(7'h2a);
        u_ctl.shift_edge(7'h2a);
        load32(1'b1, 1'b1);
        convert(130);
    endtask : test_up

    // Descending fill on port B, token dropped after first edge
    task automatic test_down;
        for (int k = 0; k < 32; k++)
        begin
            seq[k] = 7'h7f - ((k == 31) ? 7'h7f : 7'(k * 4));
            col[31-k] = seq[k];
        end
        load32(1'b0, 1'b0);
        convert(40);
    endtask : test_down

    initial
    begin
        resetn = 1'b0;
        repeat (16) @(posedge mclk);
        test_reset();
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        test_up();
        test_down();
        stop_test();
    end
endmodule : gsl_loader_tb
